// ===== logic/eai_top.sv
// Purpose: E1 receive alarm and error interrupt enables, status and request.
// Assumes: AXI4-Lite master keeps one write and one read in flight at most.
// Notes: Status clears on read and by writing ones; a new event wins over either clear.
// Operation
// - Bit 7 reads live remote alarm state, read only.
// - Declare remote alarm after A bit is one in two non-alignment frames.
// - Clear remote alarm after A bit is zero in two non-alignment frames.
// - Enable bit 5 gates interrupt on multiframe alarm declare and clear.
// - Enable bit 3 gates interrupt on each line code violation.
// - Enable bit 2 gates interrupt on frame loss declare and clear.
// - Status bits latch on event, clear when status register is read.
// - Frame loss declared after programmed count of errored alignment patterns.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module eai_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [eai_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [eai_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire eai_pkg::eai_rx_events_type rx_events,
  output eai_pkg::eai_defects_type defects,
  output logic irq
);
  import eai_pkg::*;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'b00};
    is_mapped = (a == REG_ENABLE_OFS) || (a == REG_STATUS_OFS) || (a == REG_FRAMING_OFS);
  endfunction : is_mapped

  eai_defects_type det;
  logic [7:0] enable_reg, enable_next;
  logic [7:0] status_reg, status_next;
  logic [2:0] framing_reg, framing_next;
  logic mf_prev_reg, mf_prev_next;
  logic oof_prev_reg, oof_prev_next;
  logic irq_reg, irq_next;
  logic aw_have_reg, aw_have_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] enable_view;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic do_write;
  logic do_read;

  eai_rx_defects u_defects (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(rx_events),
    .frame_loss_threshold(framing_reg),
    .defects(det)
  );

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  always_comb
  begin
    enable_next = enable_reg;
    status_next = status_reg;
    framing_next = framing_reg;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    set_bits = 8'h00;
    clr_bits = 8'h00;
    enable_view = 8'h00;
    rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wr_addr = {aw_addr_reg[ADDR_W-1:2], 2'b00};
    do_write = 1'b0;
    do_read = 1'b0;
    mf_prev_next = rx_events.mf_yellow;
    oof_prev_next = det.frame_loss;

    set_bits[BIT_MF] = rx_events.mf_yellow ^ mf_prev_reg;
    set_bits[BIT_LCV] = rx_events.lcv;
    set_bits[BIT_OOF] = det.frame_loss ^ oof_prev_reg;

    enable_view = enable_reg;
    enable_view[BIT_LIVE] = det.remote_alarm_indication;

    // Write channel capture; address and data may arrive in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      do_write = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end

    if (do_write && w_strb_reg[0])
    begin
      if (wr_addr == REG_ENABLE_OFS)
      begin
        enable_next = w_data_reg[7:0] & ENABLE_WR_MASK;
      end
      if (wr_addr == REG_STATUS_OFS)
      begin
        clr_bits = w_data_reg[7:0];
      end
      if (wr_addr == REG_FRAMING_OFS)
      begin
        framing_next = w_data_reg[2:0];
      end
    end

    if (s_axi_arvalid && s_axi_arready)
    begin
      do_read = 1'b1;
      rvalid_next = 1'b1;
      rresp_next = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      if (rd_addr == REG_ENABLE_OFS)
      begin
        rdata_next[7:0] = enable_view;
      end
      if (rd_addr == REG_STATUS_OFS)
      begin
        rdata_next[7:0] = status_reg;
        clr_bits = clr_bits | status_reg;
      end
      if (rd_addr == REG_FRAMING_OFS)
      begin
        rdata_next[2:0] = framing_reg;
      end
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end

    status_next = ((status_reg & ~clr_bits) | set_bits) & STATUS_MASK;
    irq_next = |(status_next & enable_next & STATUS_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_reg <= ENABLE_RESET;
      status_reg <= STATUS_RESET;
      framing_reg <= FRAMING_RESET;
      mf_prev_reg <= 1'b0;
      oof_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      framing_reg <= framing_next;
      mf_prev_reg <= mf_prev_next;
      oof_prev_reg <= oof_prev_next;
      irq_reg <= irq_next;
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Registered outputs keep the bus and the request free of decode glitches.
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign defects = det;
  assign irq = irq_reg;
endmodule : eai_top
`default_nettype wire

// ===== shared/eai_pkg.sv
// Purpose: Shared constants and carriers for the E1 receive alarm interrupt block.
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes: Registers are at most eight bits wide (the framing register is three) and sit in the low byte of each word.
`default_nettype none
package eai_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_ENABLE_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_FRAMING_OFS = 8'h08;
  localparam int BIT_LIVE = 7;
  localparam int BIT_MF = 5;
  localparam int BIT_LCV = 3;
  localparam int BIT_OOF = 2;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WR_MASK = 8'h3c;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_MASK = 8'h2c;
  localparam logic [2:0] FRAMING_RESET = 3'h3;
  localparam logic [2:0] OOF_COUNT_RESET = 3'h0;
  localparam logic [2:0] OOF_COUNT_MAX = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Detection time of the remote alarm, as a figure and as clock cycles at 40 MHz.
  localparam int YEL_DETECT_TIME_NS = 375000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int YEL_DETECT_CYCLES = YEL_DETECT_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    YEL_CLEAR = 2'h0,
    YEL_SET_PEND = 2'h1,
    YEL_DECLARED = 2'h3,
    YEL_CLR_PEND = 2'h2
  } eai_yel_state_type;

  typedef struct packed {
    logic nonfas_strobe;
    logic a_bit;
    logic fas_strobe;
    logic fas_errored;
    logic lcv;
    logic mf_yellow;
  } eai_rx_events_type;

  typedef struct packed {
    logic remote_alarm_indication;
    logic frame_loss;
  } eai_defects_type;
endpackage : eai_pkg
`default_nettype wire

// ===== logic/eai_rx_defects.sv
// Purpose: Remote alarm and out-of-frame defect detection from framer strobes.
// Assumes: Strobes are one-cycle pulses from framer logic on aclk.
// Notes: A threshold of zero acts as one errored pattern.
`timescale 1ns/1ps
`default_nettype none
module eai_rx_defects (
  input wire logic aclk,
  input wire logic aresetn,
  input wire eai_pkg::eai_rx_events_type ev,
  input wire logic [2:0] frame_loss_threshold,
  output eai_pkg::eai_defects_type defects
);
  import eai_pkg::*;

  eai_yel_state_type yel_reg, yel_next;
  logic [2:0] cnt_reg, cnt_next;
  logic oof_reg, oof_next;
  logic [2:0] thr;

  always_comb
  begin
    yel_next = yel_reg;
    cnt_next = cnt_reg;
    oof_next = oof_reg;
    thr = (frame_loss_threshold == 3'h0) ? 3'h1 : frame_loss_threshold;
    if (ev.nonfas_strobe)
    begin
      case (yel_reg)
        YEL_CLEAR: yel_next = ev.a_bit ? YEL_SET_PEND : YEL_CLEAR;
        YEL_SET_PEND: yel_next = ev.a_bit ? YEL_DECLARED : YEL_CLEAR;
        YEL_DECLARED: yel_next = ev.a_bit ? YEL_DECLARED : YEL_CLR_PEND;
        YEL_CLR_PEND: yel_next = ev.a_bit ? YEL_DECLARED : YEL_CLEAR;
        default: yel_next = YEL_CLEAR;
      endcase
    end
    if (ev.fas_strobe)
    begin
      if (ev.fas_errored)
      begin
        if (cnt_reg != OOF_COUNT_MAX)
        begin
          cnt_next = cnt_reg + 3'h1;
        end
        if ((cnt_reg + 3'h1) >= thr || cnt_reg == OOF_COUNT_MAX)
        begin
          oof_next = 1'b1;
        end
      end
      else
      begin
        // A good pattern ends the run and regains alignment.
        cnt_next = OOF_COUNT_RESET;
        oof_next = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      yel_reg <= YEL_CLEAR;
      cnt_reg <= OOF_COUNT_RESET;
      oof_reg <= 1'b0;
    end
    else
    begin
      yel_reg <= yel_next;
      cnt_reg <= cnt_next;
      oof_reg <= oof_next;
    end
  end

  // The pending state keeps the alarm as it was, so it is declared in YEL_DECLARED and YEL_CLR_PEND but not in YEL_SET_PEND.
  assign defects.remote_alarm_indication = (yel_reg == YEL_DECLARED) || (yel_reg == YEL_CLR_PEND);
  assign defects.frame_loss = oof_reg;
endmodule : eai_rx_defects
`default_nettype wire

// ===== sim/eai_top_assertions.sv
// Purpose: Port-level checks for the alarm interrupt block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Enable gating is internal, so the bench judges the interrupt.
`timescale 1ns/1ps
`default_nettype none
module eai_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [eai_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire eai_pkg::eai_rx_events_type rx_events,
  input wire eai_pkg::eai_defects_type defects
);
  import eai_pkg::*;
  logic last_a_reg;
  logic last_a_next;
  logic rd0;
  assign rd0 = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00;
  always_comb
  begin
    last_a_next = last_a_reg;
    if (rx_events.nonfas_strobe)
      last_a_next = rx_events.a_bit;
  end
  always_ff @(posedge aclk)
    last_a_reg <= aresetn ? last_a_next : 1'b0;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rai_set;
    rx_events.nonfas_strobe && rx_events.a_bit && last_a_reg |=> defects.remote_alarm_indication;
  endproperty
  a_rai_set: assert property (p_rai_set) else $error("alarm not declared");
  property p_rai_clr;
    rx_events.nonfas_strobe && !rx_events.a_bit && !last_a_reg
      |=> !defects.remote_alarm_indication;
  endproperty
  a_rai_clr: assert property (p_rai_clr) else $error("alarm not cleared");
  property p_rai_hold;
    !rx_events.nonfas_strobe |=> $stable(defects.remote_alarm_indication);
  endproperty
  a_rai_hold: assert property (p_rai_hold) else $error("alarm moved");
  property p_oof_good;
    rx_events.fas_strobe && !rx_events.fas_errored |=> !defects.frame_loss;
  endproperty
  a_oof_good: assert property (p_oof_good) else $error("frame loss kept");
  property p_oof_hold;
    !rx_events.fas_strobe |=> $stable(defects.frame_loss);
  endproperty
  a_oof_hold: assert property (p_oof_hold) else $error("frame loss moved");
  property p_live;
    rd0 |=> s_axi_rdata[7] == $past(defects.remote_alarm_indication);
  endproperty
  a_live: assert property (p_live) else $error("live bit wrong");
  property p_rsv;
    rd0 |=> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[6] && s_axi_rdata[1:0] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits set");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule : eai_chk
bind eai_top eai_chk u_eai_chk (.*);
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the alarm interrupt block.
// Assumes: Default frame loss threshold of three.
// Notes: Bus answers are sampled at the falling edge before the taking edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eai_pkg::*;
  logic aclk, aresetn, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  eai_rx_events_type rx_events;
  eai_defects_type defects;
  int bad_count, checks;
  eai_top u_eai_top (.*);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task close_out;
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task to;
    bad_count++;
    close_out;
  endtask : to
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
      begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    to;
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tr)
      begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    to;
  endtask : rd
  task rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, {24'h0, e});
  endtask : rc
  task ci(input logic e);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ci
  // Strobes last one cycle; the multiframe alarm level in bit 0 is kept.
  task ev(input logic [5:0] e);
    @(posedge aclk);
    rx_events <= eai_rx_events_type'(e);
    @(posedge aclk);
    rx_events <= eai_rx_events_type'({5'h0, e[0]});
  endtask : ev
  task t_reset;
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h03);
    ci(1'b0);
  endtask : t_reset
  // Software keeps bit 4 at zero, so every writable bit but that one is set here.
  task t_rw;
    wr(8'h00, 8'hef);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    rc(8'h00, 8'h2c);
  endtask : t_rw
  // A lone frame with the bit set must not declare.
  task t_rai;
    ev(6'h30);
    ev(6'h20);
    ev(6'h30);
    rc(8'h00, 8'h2c);
    ev(6'h30);
    rc(8'h00, 8'hac);
    ev(6'h20);
    rc(8'h00, 8'hac);
    ev(6'h20);
    rc(8'h00, 8'h2c);
  endtask : t_rai
  task t_lcv;
    wr(8'h00, 8'h00);
    ev(6'h02);
    ci(1'b0);
    wr(8'h00, 8'h08);
    ci(1'b1);
    rc(8'h04, 8'h08);
    ci(1'b0);
    rc(8'h04, 8'h00);
    ev(6'h02);
    ci(1'b1);
    rc(8'h04, 8'h08);
  endtask : t_lcv
  task t_oof;
    wr(8'h00, 8'h04);
    ev(6'h0c);
    ev(6'h0c);
    ci(1'b0);
    ev(6'h0c);
    ci(1'b1);
    rc(8'h04, 8'h04);
    ci(1'b0);
    ev(6'h08);
    rc(8'h04, 8'h04);
    wr(8'h08, 8'h01);
    ev(6'h0c);
    rc(8'h04, 8'h04);
    ev(6'h08);
    wr(8'h04, 8'h04);
    rc(8'h04, 8'h00);
  endtask : t_oof
  task t_mf;
    wr(8'h00, 8'h20);
    ev(6'h01);
    ci(1'b1);
    rc(8'h04, 8'h20);
    ev(6'h00);
    rc(8'h04, 8'h20);
    wr(8'h00, 8'h00);
    ev(6'h01);
    ci(1'b0);
    rc(8'h04, 8'h20);
  endtask : t_mf
  // Unmapped writes and writes without the low byte strobe must leave the enables alone.
  task t_bad;
    rd(8'h40);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(8'h40, 8'h2c);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    s_axi_wstrb <= 4'he;
    wr(8'h00, 8'h2c);
    s_axi_wstrb <= 4'hf;
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    rc(8'h00, 8'h00);
  endtask : t_bad
  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    rx_events = eai_rx_events_type'(6'h00);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_rw;
    t_rai;
    t_lcv;
    t_oof;
    t_mf;
    t_bad;
    close_out;
  end
endmodule : testbench
`default_nettype wire
